/* File: verilog/status_protect_consts.svh */
// Constant definitions for the status and protection register block.
`ifndef STATUS_PROTECT_CONSTS_SVH
`define STATUS_PROTECT_CONSTS_SVH

// Instruction codes seen on the decoded instruction strobe.
`define INS_WRITE_ENABLE       8'h06
`define INS_WRITE_DISABLE      8'h04
`define INS_WRITE_STATUS_ONE   8'h01
`define INS_WRITE_STATUS_TWO   8'h31
`define INS_WRITE_STATUS_THREE 8'h11
`define INS_SUSPEND            8'h75
`define INS_RESUME             8'h7a
`define INS_ENTER_QUAD         8'h38
`define INS_EXIT_QUAD          8'hff
`define INS_PREFIX_FIRST       8'haa
`define INS_PREFIX_SECOND      8'h55

// Field positions in the first status byte.
`define POS_WEL     1
`define POS_BP_LSB  2
`define POS_TB      5
`define POS_SEC     6
`define POS_GUARD   7

// Field positions in the second status byte.
`define POS_SRL     0
`define POS_QE      1
`define POS_LB_LSB  3
`define POS_CMP     6
`define POS_SUS     7

// Field positions in the third status byte.
`define POS_WPS     2
`define POS_DRV_LSB 5
`define POS_HOLDRST 7

// Factory reset values.
`define RST_BP      3'h0
`define RST_DRV     2'h3
`define RST_QE      1'b0
`define RST_LB      3'h0

// Output drive strength in percent.
`define DRV_PCT_FULL    7'h64
`define DRV_PCT_THREEQ  7'h4b
`define DRV_PCT_HALF    7'h32
`define DRV_PCT_QUARTER 7'h19

// Array geometry in bytes.
`define FULL_SIZE   23'h400000
`define BLOCK_SIZE  23'h010000
`define SECTOR_SIZE 23'h001000
`define TOP_ADDR    22'h3fffff

`endif

/* File: verilog/status_protect_pkg.sv */
// Types shared by the status and protection register block.
package status_protect_pkg;
   // Progress through the permanent-lock prefix sequence.
   typedef enum logic [1:0] {
      PFX_IDLE  = 2'b00,
      PFX_FIRST = 2'b01,
      PFX_ARMED = 2'b10
   } prefix_state_type;
   typedef logic [21:0] flash_addr_type;   // Byte address in the array.
   typedef logic [22:0] region_size_type;  // Region size, up to the whole array.
endpackage

/* File: verilog/protect_cfg_if.sv */
// Interface carrying protection fields to the region decoder and its result back.
`timescale 1ns/1ps
`default_nettype none
interface protect_cfg_if;
   import status_protect_pkg::*;
   logic           sec;   // Fine grain select.
   logic           tb;    // Top or bottom select.
   logic           cmp;   // Complement protect.
   logic           protect_scheme_select;   // Protect scheme select.
   logic [2:0]     bp;    // Block protect field.
   logic           none;  // No area protected by the field scheme.
   flash_addr_type lo;    // Lowest protected byte.
   flash_addr_type hi;    // Highest protected byte.
   modport cfg (output sec, tb, cmp, protect_scheme_select, bp, input none, lo, hi);
   modport dec (input sec, tb, cmp, protect_scheme_select, bp, output none, lo, hi);
endinterface
`default_nettype wire

/* File: verilog/protect_region_decode.sv */
// Decoder from the protection fields to one contiguous protected address range.
`timescale 1ns/1ps
`default_nettype none
`include "status_protect_consts.svh"
module protect_region_decode
   import status_protect_pkg::*;
(
   protect_cfg_if.dec cfg
);

   ////////////////////////////////////////////////////////////////////////////
   // Size selected by the field before any complement is applied.
   function automatic region_size_type base_size(input logic sec, input logic [2:0] bp);
      region_size_type size;
      size = '0;
      if (bp == 3'h0) begin
         size = '0;
      end else if (bp == 3'h7) begin
         size = `FULL_SIZE;
      end else if (sec) begin
         // Sector steps stop at 32KB, so codes 100 to 110 all mean 32KB.
         size = bp[2] ? (`SECTOR_SIZE << 2'h3) : (`SECTOR_SIZE << (bp[1:0] - 2'h1));
      end else begin
         size = `BLOCK_SIZE << (bp - 3'h1);
      end
      return size;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // The complement of a top region is a bottom region of the remaining size,
   // so one size and one side describe both cases without a second table.
   always_comb begin
      region_size_type size;
      logic            bottom;
      size   = base_size(cfg.sec, cfg.bp);
      bottom = cfg.tb;
      if (cfg.cmp) begin
         size   = `FULL_SIZE - size;
         bottom = ~cfg.tb;
      end
      // The field scheme steps aside when the lock array is selected.
      cfg.none = cfg.protect_scheme_select || (size == '0);
      if (bottom) begin
         cfg.lo = '0;
         cfg.hi = 22'(size - 23'h1);
      end else begin
         cfg.lo = 22'(`FULL_SIZE - size);
         cfg.hi = `TOP_ADDR;
      end
   end

endmodule
`default_nettype wire

/* File: verilog/status_protect_regs.sv */
// Status and configuration register bank with status-write protection.
// Operation
// - Guard bit selects software or pin protection.
// - Lockdown bit: temporary or permanent status lock.
// - Guard and lockdown clear: writes need latch.
// - Guard set, pin low: reject status writes.
// - Guard set, pin high: writes need latch.
// - Lockdown refuses writes until power cycle.
// - Prefix pair before lockdown write makes permanent.
// - Suspend flag set by suspend, cleared by resume.
// - Three sticky one-time security area lock bits.
// - Quad enable turns protect and pause pins off.
// - Enter four-wire mode ignored without quad enable.
// - Four-wire mode keeps quad enable set.
// - Scheme select picks field or lock array.
// - Lock array preset to ones after reset.
// - Two drive bits decode strength, default quarter.
// - Pin select bit: pause or reset input.
// - Quad enable disables pause and reset functions.
// - Reserved bits ignore writes, read as zero.
// - Protect field decodes top or bottom region.
// - Complement bit inverts the protected region.
// - Write enable instruction sets the latch.
`timescale 1ns/1ps
`default_nettype none
`include "status_protect_consts.svh"
module status_protect_regs
   import status_protect_pkg::*;
(
   input  wire logic        SYS_CLK,            // System clock, 20 MHz.
   input  wire logic        RESET,              // Synchronous reset, active high.
   input  wire logic        POWER_CYCLE,        // Pulse marking a power-down, power-up cycle.
   input  wire logic        WP_N_PIN,           // Write-protect pin, active low, asynchronous.
   input  wire logic        INSTR_VALID,        // Pulse: one decoded instruction.
   input  wire logic [7:0]  INSTR_CODE,         // Instruction code with the pulse.
   input  wire logic [7:0]  INSTR_DATA,         // Data byte for status writes.
   output var  logic [7:0]  STATUS_ONE,         // First status byte.
   output var  logic [7:0]  STATUS_TWO,         // Second status byte.
   output var  logic [7:0]  STATUS_THREE,       // Third status byte.
   output var  logic        FOUR_WIRE_MODE,     // Four-wire command mode active.
   output var  logic        WP_PIN_ACTIVE,      // Protect pin carries its control function.
   output var  logic        PAUSE_PIN_ENABLE,   // Shared pin acts as bus pause.
   output var  logic        RESET_PIN_ENABLE,   // Shared pin acts as hardware reset.
   output var  logic [6:0]  DRIVE_PERCENT,      // Read output drive strength.
   output var  logic        LOCK_ARRAY_PRESET,  // Pulse: set all lock array bits to one.
   output var  logic        AREA_PROTECT_NONE,  // Field scheme protects nothing.
   output var  logic [21:0] AREA_PROTECT_LO,    // Lowest protected byte.
   output var  logic [21:0] AREA_PROTECT_HI,    // Highest protected byte.
   output var  logic        STATUS_LOCKED_FOREVER, // Permanent status lock taken.
   output var  logic        WRITE_REFUSED       // Pulse: a status write was discarded.
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic             wp_s1_r, wp_s2_r, wp_s3_r; // Pin synchroniser chain.
   logic             wp_high_r;                 // Debounced pin level.
   logic             wel_r;                     // Write enable latch.
   logic             guard_r;                   // Status guard bit.
   logic             sec_r, tb_r;               // Fine grain and top/bottom select.
   logic [2:0]       bp_r;                      // Block protect field.
   logic             srl_r;                     // Status lockdown bit.
   logic             otp_r;                     // Permanent lock, survives power cycles.
   logic             qe_r;                      // Quad enable.
   logic [2:0]       lock_r;                    // Security area locks, three down to one.
   logic             cmp_r;                     // Complement protect.
   logic             sus_r;                     // Erase paused flag.
   logic             wps_r;                     // Protect scheme select.
   logic [1:0]       drv_r;                     // Drive strength, high and low bit.
   logic             hold_rst_r;                // Shared pin function select.
   logic             quad_r;                    // Four-wire command mode.
   prefix_state_type pfx_r, pfx_nxt;            // Prefix sequence tracker.
   logic             is_wr, write_ok, accept;   // Status write decode.
   protect_cfg_if    pcfg();                    // Link to the region decoder.

   ////////////////////////////////////////////////////////////////////////////
   // True for any of the three status write instructions.
   function automatic logic is_status_write(input logic [7:0] code);
      return (code == `INS_WRITE_STATUS_ONE) || (code == `INS_WRITE_STATUS_TWO) ||
             (code == `INS_WRITE_STATUS_THREE);
   endfunction

   // Percent figure for the two drive bits.
   function automatic logic [6:0] drive_pct(input logic [1:0] drv);
      logic [6:0] pct;
      pct = `DRV_PCT_QUARTER;
      case (drv)
         2'h0: pct = `DRV_PCT_FULL;
         2'h1: pct = `DRV_PCT_THREEQ;
         2'h2: pct = `DRV_PCT_HALF;
         default: pct = `DRV_PCT_QUARTER;
      endcase
      return pct;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // The pin is asynchronous, so it passes three flops and a new level is only
   // believed once the second and third stages agree.
   always_ff @(posedge SYS_CLK) begin
      wp_s1_r <= WP_N_PIN;
      wp_s2_r <= wp_s1_r;
      wp_s3_r <= wp_s2_r;
      if (RESET) begin
         wp_high_r <= 1'b1;
      end else if (wp_s2_r == wp_s3_r) begin
         wp_high_r <= wp_s3_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write permission. The pin only counts while quad enable is clear, because
   // with quad enable set the pin is a data line.
   assign is_wr    = INSTR_VALID && is_status_write(INSTR_CODE);
   assign write_ok = wel_r &&
                     !srl_r && !otp_r &&
                     !(guard_r && !qe_r && !wp_high_r);
   assign accept   = is_wr && write_ok && !POWER_CYCLE;

   ////////////////////////////////////////////////////////////////////////////
   // Write enable latch: set by write enable, cleared by write disable, by any
   // status write and by a power cycle.
   always_ff @(posedge SYS_CLK) begin
      if (RESET || POWER_CYCLE) begin
         wel_r <= 1'b0;
      end else if (INSTR_VALID && INSTR_CODE == `INS_WRITE_ENABLE) begin
         wel_r <= 1'b1;
      end else if (is_wr || (INSTR_VALID && INSTR_CODE == `INS_WRITE_DISABLE)) begin
         wel_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // First status byte fields. These are non-volatile, so a power cycle keeps them.
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         guard_r <= 1'b0;
         sec_r   <= 1'b0;
         tb_r    <= 1'b0;
         bp_r    <= `RST_BP;
      end else if (accept && INSTR_CODE == `INS_WRITE_STATUS_ONE) begin
         guard_r <= INSTR_DATA[`POS_GUARD];
         sec_r   <= INSTR_DATA[`POS_SEC];
         tb_r    <= INSTR_DATA[`POS_TB];
         bp_r    <= INSTR_DATA[`POS_BP_LSB +: 3];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Second status byte fields. The lockdown bit is volatile unless made
   // permanent; the security locks only ever gain ones.
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         srl_r  <= 1'b0;
         otp_r  <= 1'b0;
         qe_r   <= `RST_QE;
         lock_r <= `RST_LB;
         cmp_r  <= 1'b0;
      end else if (POWER_CYCLE) begin
         // A permanent lock holds the lockdown bit through the cycle.
         srl_r <= otp_r;
      end else if (accept && INSTR_CODE == `INS_WRITE_STATUS_TWO) begin
         srl_r  <= INSTR_DATA[`POS_SRL];
         // Only the prefix pair right before this write makes the lock permanent.
         otp_r  <= INSTR_DATA[`POS_SRL] && (pfx_r == PFX_ARMED);
         qe_r   <= INSTR_DATA[`POS_QE] || quad_r;
         lock_r <= lock_r | INSTR_DATA[`POS_LB_LSB +: 3];
         cmp_r  <= INSTR_DATA[`POS_CMP];
         // The suspend flag and the reserved bit of this byte are not writable.
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Third status byte fields. Reserved positions are simply never stored.
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         wps_r      <= 1'b0;
         drv_r      <= `RST_DRV;
         hold_rst_r <= 1'b0;
      end else if (accept && INSTR_CODE == `INS_WRITE_STATUS_THREE) begin
         wps_r      <= INSTR_DATA[`POS_WPS];
         drv_r      <= INSTR_DATA[`POS_DRV_LSB +: 2];
         hold_rst_r <= INSTR_DATA[`POS_HOLDRST];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Suspend flag and four-wire command mode, both volatile.
   always_ff @(posedge SYS_CLK) begin
      if (RESET || POWER_CYCLE) begin
         sus_r  <= 1'b0;
         quad_r <= 1'b0;
      end else if (INSTR_VALID) begin
         if (INSTR_CODE == `INS_SUSPEND) begin
            sus_r <= 1'b1;
         end else if (INSTR_CODE == `INS_RESUME) begin
            sus_r <= 1'b0;
         end
         if (INSTR_CODE == `INS_ENTER_QUAD && qe_r) begin
            quad_r <= 1'b1;
         end else if (INSTR_CODE == `INS_EXIT_QUAD) begin
            quad_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prefix tracker. The pair must be the last two instructions before the
   // lockdown write; anything else in between disarms it, which keeps a stray
   // byte from making the lock permanent.
   always_comb begin
      pfx_nxt = pfx_r;
      case (pfx_r)
         PFX_IDLE: begin
            if (INSTR_CODE == `INS_PREFIX_FIRST) begin
               pfx_nxt = PFX_FIRST;
            end
         end
         PFX_FIRST: begin
            pfx_nxt = (INSTR_CODE == `INS_PREFIX_SECOND) ? PFX_ARMED : PFX_IDLE;
         end
         default: begin
            pfx_nxt = PFX_IDLE;
         end
      endcase
   end

   // State register for the prefix tracker.
   always_ff @(posedge SYS_CLK) begin
      if (RESET || POWER_CYCLE) begin
         pfx_r <= PFX_IDLE;
      end else if (INSTR_VALID) begin
         pfx_r <= pfx_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Region decoder for the field scheme.
   assign pcfg.sec = sec_r;
   assign pcfg.tb  = tb_r;
   assign pcfg.cmp = cmp_r;
   assign pcfg.protect_scheme_select = wps_r;
   assign pcfg.bp  = bp_r;

   protect_region_decode u_decode (
      .cfg (pcfg.dec)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output registers. Every output lags the internal state by one cycle, a
   // trade for clean flop-driven outputs. Reserved bits read as zero.
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         STATUS_ONE            <= 8'h00;
         STATUS_TWO            <= 8'h00;
         STATUS_THREE          <= 8'h00;
         FOUR_WIRE_MODE        <= 1'b0;
         WP_PIN_ACTIVE         <= 1'b0;
         PAUSE_PIN_ENABLE      <= 1'b0;
         RESET_PIN_ENABLE      <= 1'b0;
         DRIVE_PERCENT         <= `DRV_PCT_QUARTER;
         LOCK_ARRAY_PRESET     <= 1'b1;
         AREA_PROTECT_NONE     <= 1'b1;
         AREA_PROTECT_LO       <= 22'h000000;
         AREA_PROTECT_HI       <= 22'h000000;
         STATUS_LOCKED_FOREVER <= 1'b0;
         WRITE_REFUSED         <= 1'b0;
      end else begin
         STATUS_ONE            <= {guard_r, sec_r, tb_r, bp_r, wel_r, 1'b0};
         STATUS_TWO            <= {sus_r, cmp_r, lock_r, 1'b0, qe_r, srl_r};
         STATUS_THREE          <= {hold_rst_r, drv_r, 2'b00, wps_r, 2'b00};
         FOUR_WIRE_MODE        <= quad_r;
         WP_PIN_ACTIVE         <= !qe_r;
         PAUSE_PIN_ENABLE      <= !qe_r && !hold_rst_r;
         RESET_PIN_ENABLE      <= !qe_r && hold_rst_r;
         DRIVE_PERCENT         <= drive_pct(drv_r);
         LOCK_ARRAY_PRESET     <= POWER_CYCLE;
         AREA_PROTECT_NONE     <= pcfg.none;
         AREA_PROTECT_LO       <= pcfg.lo;
         AREA_PROTECT_HI       <= pcfg.hi;
         STATUS_LOCKED_FOREVER <= otp_r;
         WRITE_REFUSED         <= is_wr && !accept;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions and coverage.
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   logic [15:0] cfg_bundle;  // All writable status fields together.
   assign cfg_bundle = {guard_r, sec_r, tb_r, bp_r, srl_r, qe_r, lock_r, cmp_r, wps_r, drv_r, hold_rst_r};

   a_needs_latch: assert property (is_wr && !wel_r && !POWER_CYCLE |=> $stable(cfg_bundle))
      else $error("status changed without the write enable latch");
   a_pin_low_blocks: assert property (is_wr && guard_r && !qe_r && !wp_high_r && !POWER_CYCLE
      |=> $stable(cfg_bundle) && WRITE_REFUSED)
      else $error("status write passed while the protect pin was low");
   a_lockdown_blocks: assert property (srl_r && is_wr && !POWER_CYCLE |=> $stable(cfg_bundle))
      else $error("status write passed under lockdown");
   a_power_unlocks: assert property (POWER_CYCLE && !otp_r |=> !srl_r)
      else $error("power cycle did not clear the lockdown bit");
   a_lock_permanent: assert property (otp_r |=> otp_r && srl_r ##1 STATUS_LOCKED_FOREVER)
      else $error("permanent status lock was lost");
   a_suspend_sets: assert property (INSTR_VALID && INSTR_CODE == `INS_SUSPEND && !POWER_CYCLE
      |=> sus_r ##1 STATUS_TWO[`POS_SUS])
      else $error("suspend flag not set after suspend");
   a_locks_sticky: assert property (1'b1 |=> (lock_r & $past(lock_r)) == $past(lock_r))
      else $error("security area lock bit cleared");
   a_quad_needs_qe: assert property (INSTR_VALID && INSTR_CODE == `INS_ENTER_QUAD && !qe_r && !quad_r
      |=> !quad_r)
      else $error("four-wire mode entered without quad enable");
   a_quad_keeps_qe: assert property (quad_r |-> qe_r)
      else $error("quad enable clear in four-wire mode");
   a_pin_functions: assert property (qe_r |=> !PAUSE_PIN_ENABLE && !RESET_PIN_ENABLE && !WP_PIN_ACTIVE)
      else $error("pin control function left on with quad enable");
   a_preset_power: assert property (POWER_CYCLE |=> LOCK_ARRAY_PRESET ##1 (!LOCK_ARRAY_PRESET || $past(POWER_CYCLE)))
      else $error("lock array preset missing after power cycle");

   c_write_taken: cover property (accept ##1 !wel_r);
   c_write_refused: cover property (is_wr && !accept ##1 WRITE_REFUSED);
   c_lock_forever: cover property ($rose(otp_r));
   c_quad_entered: cover property ($rose(quad_r));

endmodule
`default_nettype wire

/* File: dv/host_instr_model.sv */
// Host controller model issuing decoded status instructions.
`timescale 1ns/1ps
`default_nettype none
module host_instr_model (
   input  wire logic       clk,   // System clock.
   output var  logic       valid, // Instruction strobe.
   output var  logic [7:0] code,  // Instruction code.
   output var  logic [7:0] data   // Status data byte.
);
   initial begin
      valid = 1'b0;
      code  = 8'h00;
      data  = 8'h00;
   end
   // Raise one instruction; it is taken at the next edge.
   task automatic send(input logic [7:0] c, input logic [7:0] d);
      valid <= 1'b1;
      code  <= c;
      data  <= d;
      @(posedge clk);
   endtask
   // Release the strobe; stale fields are inverted so nothing leans on them.
   task automatic idle();
      valid <= 1'b0;
      code  <= ~code;
      data  <= ~data;
      @(posedge clk);
      #1;
   endtask
   // The two prefix bytes must directly precede the lockdown write.
   task automatic lock_forever(input logic [7:0] d);
      send(8'h06, 8'h00);
      send(8'haa, 8'h00);
      send(8'h55, 8'h00);
      send(8'h31, d);
      idle();
   endtask
endmodule
`default_nettype wire

/* File: dv/status_protect_regs_tb.sv */
// Self-checking bench for the status and protection register bank.
`timescale 1ns/1ps
`default_nettype none
module status_protect_regs_tb;
   import status_protect_pkg::*;
   logic clk = 1'b0, rst = 1'b1, pc = 1'b0, wp_n = 1'b1;
   logic iv;
   logic [7:0] ic, id, s1, s2, s3;
   logic fw, wpa, pse, rse, pre, non, lkf, ref_p;
   logic [6:0] drv;
   logic [21:0] lo, hi;
   int n_errors = 0, num_checks = 0, cyc = 0;
   int n_ref = 0;  // Refusal pulses seen; the pulse stands one cycle only.
   initial forever #25 clk = ~clk;
   host_instr_model i_host (.clk(clk), .valid(iv), .code(ic), .data(id));
   status_protect_regs i_dut (.SYS_CLK(clk), .RESET(rst), .POWER_CYCLE(pc),
      .WP_N_PIN(wp_n), .INSTR_VALID(iv), .INSTR_CODE(ic), .INSTR_DATA(id),
      .STATUS_ONE(s1), .STATUS_TWO(s2), .STATUS_THREE(s3), .FOUR_WIRE_MODE(fw),
      .WP_PIN_ACTIVE(wpa), .PAUSE_PIN_ENABLE(pse), .RESET_PIN_ENABLE(rse),
      .DRIVE_PERCENT(drv), .LOCK_ARRAY_PRESET(pre), .AREA_PROTECT_NONE(non),
      .AREA_PROTECT_LO(lo), .AREA_PROTECT_HI(hi), .STATUS_LOCKED_FOREVER(lkf),
      .WRITE_REFUSED(ref_p));
   ////////////////////////////////////////////////////////////////////////////
   // Compare one value and count it.
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Single instruction, then let its result land.
   task automatic cmd(input logic [7:0] c, input logic [7:0] d);
      i_host.send(c, d);
      i_host.idle();
   endtask
   // Status write preceded by write enable.
   task automatic wen(input logic [7:0] c, input logic [7:0] d);
      i_host.send(8'h06, 8'h00);
      cmd(c, d);
   endtask
   // Power-cycle pulse; the lock array preset must follow at the next edge.
   // The preset stands for the single cycle after the pulse is taken.
   task automatic power_cycle();
      pc <= 1'b1;
      @(posedge clk);
      #1 check("preset", pre, 1);
      pc <= 1'b0;
      @(posedge clk);
      #1 check("preset", pre, 0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Hang guard: the sequence needs well under a thousand cycles.
   // The refusal pulse is counted at the edge that ends it, before it updates.
   always @(posedge clk) begin
      cyc++;
      if (ref_p === 1'b1) n_ref++;
      if (cyc > 5000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      static logic [7:0] fd [5] = '{8'h00, 8'h1c, 8'h04, 8'h38, 8'h68};
      static logic [21:0] flo [5] = '{0, 0, 22'h3f0000, 0, 0};
      static logic [21:0] fhi [5] = '{0, 22'h3fffff, 22'h3fffff, 22'h1fffff, 22'h001fff};
      static logic [6:0] pct [4] = '{7'h64, 7'h4b, 7'h32, 7'h19};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 check("s3", s3, 8'h60);
      check("drv", drv, 7'h19);
      check("s1", s1, 8'h00);
      check("pins", {wpa, pse, rse}, 3'b110);
      cmd(8'h38, 8'h00);
      check("fw", fw, 0);
      cmd(8'h01, 8'h1c);
      check("s1", s1, 8'h00);
      check("ref", n_ref, 1);
      // Latch set by write enable and cleared by write disable.
      cmd(8'h06, 8'h00);
      check("s1", s1, 8'h02);
      cmd(8'h04, 8'h00);
      check("s1", s1, 8'h00);
      // Field decoding, one row per entry.
      for (int i = 0; i < 5; i++) begin
         wen(8'h01, fd[i]);
         check("s1", s1, fd[i]);
         check("none", non, i == 0);
         if (i > 0) check("lo", lo, flo[i]);
         if (i > 0) check("hi", hi, fhi[i]);
      end
      // Complement of the lowest 8KB is everything above it.
      wen(8'h31, 8'h40);
      check("s2", s2, 8'h40);
      check("none", non, 0);
      check("lo", lo, 22'h002000);
      check("hi", hi, 22'h3fffff);
      // Reserved bits are written as ones and must not stick.
      for (int i = 0; i < 4; i++) begin
         wen(8'h11, {1'b0, i[1:0], 5'h1b});
         check("s3", s3, {1'b0, i[1:0], 5'h00});
         check("drv", drv, pct[i]);
      end
      wen(8'h11, 8'h84);
      check("rst pin", {rse, pse, non}, 3'b101);
      wen(8'h31, 8'h02);
      check("qe pins", {wpa, rse}, 2'b00);
      cmd(8'h38, 8'h00);
      check("fw", fw, 1);
      wen(8'h31, 8'h00);
      check("s2", s2, 8'h02);
      cmd(8'hff, 8'h00);
      wen(8'h31, 8'h08);
      wen(8'h31, 8'h00);
      check("s2", s2, 8'h08);
      cmd(8'h75, 8'h00);
      wen(8'h31, 8'h08);
      check("s2", s2, 8'h88);
      cmd(8'h7a, 8'h00);
      check("s2", s2, 8'h08);
      // Guard bit with the protect pin low, then high.
      wen(8'h01, 8'h80);
      wp_n <= 1'b0;
      repeat (8) @(posedge clk);
      wen(8'h01, 8'h84);
      check("s1", s1, 8'h80);
      check("ref", n_ref, 2);
      wp_n <= 1'b1;
      repeat (8) @(posedge clk);
      wen(8'h01, 8'h04);
      check("s1", s1, 8'h04);
      wen(8'h31, 8'h09);
      wen(8'h01, 8'h00);
      check("s1", s1, 8'h04);
      check("ref", n_ref, 3);
      power_cycle();
      check("s2", s2, 8'h08);
      i_host.lock_forever(8'h09);
      check("forever", lkf, 1);
      power_cycle();
      wen(8'h01, 8'h00);
      check("s1", s1, 8'h04);
      check("forever", lkf, 1);
      check("ref", n_ref, 4);
      complete_run();
   end
endmodule
`default_nettype wire
